// ===== dv/csd_clock_select_asserts.sv
// Port-level checker for the clock select block
`timescale 1ns/100ps
module csd_clock_select_asserts (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [7:0] sfrAddr,
  input wire logic       sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic       sfrRdEn,
  input wire logic [7:0] sfrRdData,
  input wire logic       oscPrecisionIn,
  input wire logic       oscExternalIn,
  input wire logic       oscRtcIn,
  input wire logic       oscLowPowerIn,
  input wire logic       coreClockOut,
  input wire logic       lowPowerOscEnable,
  input wire logic       extOscEnable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  logic wrSel;
  logic rdExtQ;
  assign wrSel = sfrWrEn && sfrAddr == 8'ha9;
  // Remember an ext control read so its data is judged a cycle later
  always_ff @(posedge clock or posedge rst) begin
    if (rst) rdExtQ <= 1'b0;
    else rdExtQ <= sfrRdEn && sfrAddr == 8'hb1;
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_bit3_zero: assert property (sfrRdData[3] == 1'b0)
    else $error("unused bit read as one");
  a_cmos_no_valid: assert property (rdExtQ && sfrRdData[6:5] == 2'b01 |-> !sfrRdData[7])
    else $error("valid flag set in cmos mode");
  a_reset_defaults: assert property ($fell(rst) |-> lowPowerOscEnable && !coreClockOut)
    else $error("wrong state after reset");
  a_lp_off_sel: assert property (wrSel && sfrWrData[2:0] inside {3'h0, 3'h1, 3'h3}
    |-> ##[1:2] !lowPowerOscEnable)
    else $error("low power osc kept on");
  a_lp_on_sel: assert property (wrSel && sfrWrData[2:0] == 3'h4 |-> ##[1:2] lowPowerOscEnable)
    else $error("low power osc not enabled");
  a_reserved_keep: assert property (wrSel && sfrWrData[2:0] inside {3'h2, 3'h5, 3'h6, 3'h7}
    |-> ##2 $stable(lowPowerOscEnable) [*2])
    else $error("reserved source changed active source");
  a_no_runt: assert property (coreClockOut |=> !coreClockOut)
    else $error("back to back core clock ticks");
  a_read_hold: assert property (!$past(sfrRdEn) |-> $stable(sfrRdData))
    else $error("read data moved without a read");
  c_tick: cover property (coreClockOut);
  c_valid: cover property (rdExtQ && sfrRdData[7]);
  c_ext_sel: cover property (wrSel && sfrWrData[2:0] == 3'h1);
endmodule : csd_clock_select_asserts

bind csd_clock_select csd_clock_select_asserts csd_clock_select_asserts_i (
  .clock(clock), .rst(rst), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
  .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .oscPrecisionIn(oscPrecisionIn),
  .oscExternalIn(oscExternalIn), .oscRtcIn(oscRtcIn), .oscLowPowerIn(oscLowPowerIn),
  .coreClockOut(coreClockOut), .lowPowerOscEnable(lowPowerOscEnable),
  .extOscEnable(extOscEnable));

// ===== dv/csd_clock_select_tb.sv
// Self-checking bench for the clock select block
`timescale 1ns/100ps
module csd_clock_select_tb;
  logic       clock, rst, sfrWrEn, sfrRdEn, coreClockOut, lowPowerOscEnable, extOscEnable;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, rd, rnd, dat;
  logic [3:0] osc = 4'h0;
  int         n_fail, num_checks, cyc, t0, k;
  int         per[5] = '{6, 8, 12, 10, 10};
  int         src[5] = '{0, 1, 4, 3, 2};
  csd_clock_select csd_clock_select_i (.clock(clock), .rst(rst), .sfrAddr(sfrAddr),
    .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
    .oscPrecisionIn(osc[0]), .oscExternalIn(osc[1]), .oscRtcIn(osc[3]),
    .oscLowPowerIn(osc[2]), .coreClockOut(coreClockOut),
    .lowPowerOscEnable(lowPowerOscEnable), .extOscEnable(extOscEnable));
  // ------------------------------------------------------------
  // Clock, oscillators and hang guard
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Oscillators run from the cycle count so tick spacing is exact
  always @(posedge clock) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 4; i++) osc[i] <= (cyc % per[i]) < per[i] / 2;
    if (cyc == 80000) begin
      n_fail++;
      complete_run();
    end
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWrEn <= 1'b1;
    @(posedge clock);
    sfrWrEn <= 1'b0;
  endtask : wr
  task automatic rd8(input logic [7:0] a);
    @(posedge clock);
    sfrAddr <= a;
    sfrRdEn <= 1'b1;
    @(posedge clock);
    sfrRdEn <= 1'b0;
    @(negedge clock);
    rd = sfrRdData;
  endtask : rd8
  // Waits for one core tick; gaps longer than any period count as a hang
  task automatic tick();
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (coreClockOut !== 1'b1 && k < 2000);
  endtask : tick
  task automatic interval(input int exp);
    // The first tick after a switch may still come from the old source
    tick();
    tick();
    t0 = cyc;
    tick();
    check(16'(cyc - t0), 16'(exp)); // Tick spacing
  endtask : interval
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {rst, sfrWrEn, sfrRdEn, sfrAddr, sfrWrData} = '0;
    rst = 1'b1;
    rnd = 8'h51;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rd8(8'ha9);
    check(rd, 8'h34); // Select reset value
    rd8(8'hb1);
    check(rd, 8'h00);
    check({extOscEnable, lowPowerOscEnable}, 2'b01); // Only low power on
    // Random unmapped reads return zero
    repeat (4) begin
      rnd = lfsr(rnd);
      if (rnd != 8'ha9 && rnd != 8'hb1) begin
        rd8(rnd);
        check(rd, 8'h00);
      end
    end
    wr(8'ha9, 8'h30);
    // Walk divide codes down, each write just after a tick so ready is still low
    for (int d = 7; d >= 0; d--) begin
      rnd = lfsr(rnd);
      tick();
      wr(8'ha9, {1'b0, 3'(d), rnd[0], 3'h0});
      rd8(8'ha9);
      check(rd, {1'b0, 3'(d), 4'h0}); // Ready low, unused bit clear
      t0 = cyc;
      do rd8(8'ha9); while (rd[7] !== 1'b1 && cyc - t0 < 1000);
      check(16'(cyc - t0 <= 128 * 6 + 16), 16'h1); // Applied in time
      interval(6 << d);
    end
    wr(8'hb1, 8'h47); // RC mode, top bias band for a fast network
    t0 = cyc;
    do rd8(8'hb1); while (rd[7] !== 1'b1 && cyc - t0 < 9000);
    check(rd, 8'hc7); // Valid before switching to it
    // Switch sources at divide one while running; reserved code keeps the RTC source
    for (int i = 0; i < 5; i++) begin
      wr(8'ha9, 8'(src[i]));
      interval(per[i]); // Source period
      check(lowPowerOscEnable, i == 2); // Auto enable
    end
    // Fast to slow: divide first, wait for ready, then the slower source
    // Flash timing lies outside this block, so no flash step goes with it
    wr(8'ha9, 8'h13);
    t0 = cyc;
    do rd8(8'ha9); while (rd[7] !== 1'b1 && cyc - t0 < 1000);
    check(rd, 8'h93); // Divide two applied on the kept source
    wr(8'ha9, 8'h14);
    interval(2 * per[2]); // Low power halved
    check(lowPowerOscEnable, 1'b1);
    // Slow to fast: source first, then divide, then wait for ready
    wr(8'ha9, 8'h10);
    wr(8'ha9, 8'h00); // Divide by one kept from here on
    t0 = cyc;
    do rd8(8'ha9); while (rd[7] !== 1'b1 && cyc - t0 < 1000);
    check(rd, 8'h80);
    interval(per[0]); // Precision undivided
    check(lowPowerOscEnable, 1'b0);
    // External modes: valid only in RC, capacitor and crystal modes after start-up
    for (int m = 2; m < 7; m++) begin
      rnd = lfsr(rnd);
      dat = {1'b0, 3'(m), 1'b0, (m >= 4) ? 3'h7 : rnd[2:0]};
      wr(8'hb1, dat);
      rd8(8'hb1);
      check(rd, dat); // Not valid right after enable
      repeat (8400) @(posedge clock); // Enable then wait, as for RC
      rd8(8'hb1);
      check(rd, dat | (m >= 4 ? 8'h80 : 8'h00)); // Valid flag
      check(extOscEnable, 1'b1);
    end
    complete_run();
  end
endmodule : csd_clock_select_tb

// ===== include/csd_defines.svh
// Register offsets, field positions, reset values and timing counts of the clock select block
`ifndef CSD_DEFINES_SVH
`define CSD_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CSD_ADDR_CLOCK_SELECT    8'ha9
`define CSD_ADDR_EXT_OSC_CONTROL 8'hb1

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CSD_READY_BIT      7
`define CSD_DIV_MSB        6
`define CSD_DIV_LSB        4
`define CSD_UNUSED_BIT     3
`define CSD_SRC_MSB        2
`define CSD_SRC_LSB        0
`define CSD_XVALID_BIT     7
`define CSD_XMODE_MSB      6
`define CSD_XMODE_LSB      4
`define CSD_XBIAS_MSB      2
`define CSD_XBIAS_LSB      0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CSD_RST_DIV        3'h3
`define CSD_RST_SRC        3'h4
`define CSD_RST_XMODE      3'h0
`define CSD_RST_XBIAS      3'h0

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define CSD_CLK_PERIOD_NS  8
`define CSD_XGAP_NS        10000
`define CSD_XGAP_CYCLES    (`CSD_XGAP_NS / `CSD_CLK_PERIOD_NS)
`define CSD_XSTART_TICKS   11'h400

`endif

// ===== include/csd_pkg.sv
// Types shared by the clock select block
package csd_pkg;

  // Undivided source codes
  typedef enum logic [2:0] {
    SRC_PRECISION = 3'b000,
    SRC_EXTERNAL  = 3'b001,
    SRC_RTC       = 3'b011,
    SRC_LOW_POWER = 3'b100
  } csd_src_t;

  // External oscillator modes
  typedef enum logic [2:0] {
    XM_OFF0      = 3'b000,
    XM_OFF1      = 3'b001,
    XM_CMOS      = 3'b010,
    XM_CMOS_DIV2 = 3'b011,
    XM_RC        = 3'b100,
    XM_CAP       = 3'b101,
    XM_XTAL_DIV2 = 3'b110,
    XM_RSVD      = 3'b111
  } csd_xmode_t;

endpackage : csd_pkg

// ===== verilog/csd_clock_select.sv
// System clock source select, power-of-two divider and external oscillator valid detector
`timescale 1ns/100ps
`include "csd_defines.svh"
module csd_clock_select (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrEn,
  input  wire logic [7:0] sfrWrData,
  input  wire logic       sfrRdEn,
  output logic      [7:0] sfrRdData,
  input  wire logic       oscPrecisionIn,
  input  wire logic       oscExternalIn,
  input  wire logic       oscRtcIn,
  input  wire logic       oscLowPowerIn,
  output logic            coreClockOut,
  output logic            lowPowerOscEnable,
  output logic            extOscEnable
);

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  logic [3:0]  pinIn;
  logic [3:0]  tick;
  logic [2:0]  divSel_q;
  logic [2:0]  srcSel_q;
  logic [2:0]  activeDiv_q;
  logic        applied_q;
  logic [6:0]  divCnt_q;
  logic [6:0]  divLast;
  logic        coreTick_q;
  csd_pkg::csd_src_t  activeSrc_q;
  csd_pkg::csd_xmode_t xMode_q;
  logic [2:0]  xBias_q;
  logic        xHalf_q;
  logic        extRaw;
  logic        extTick;
  logic        srcTick;
  logic        xRunMode;
  logic        xCmosMode;
  logic [10:0] xStartCnt_q;
  logic [10:0] xGapCnt_q;
  logic        xValid_q;
  logic        dividerReady;
  logic        xValidRead;
  logic [7:0]  rdData_q;

  // ----------------------------------------------------------------------------
  // Oscillator pin synchronisers
  // ----------------------------------------------------------------------------
  assign pinIn = {oscLowPowerIn, oscRtcIn, oscExternalIn, oscPrecisionIn};

  // One synchroniser per oscillator; each yields a one-cycle tick per rising source edge
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gSync
      csd_pin_sync uSync (
        .clock     (clock),
        .rst       (rst),
        .pinIn     (pinIn[g]),
        .risePulse (tick[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------------
  // Select register; bit 3 is never stored so it always reads 0
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      divSel_q <= `CSD_RST_DIV;
      srcSel_q <= `CSD_RST_SRC;
    end else if (sfrWrEn && sfrAddr == `CSD_ADDR_CLOCK_SELECT) begin
      divSel_q <= sfrWrData[`CSD_DIV_MSB:`CSD_DIV_LSB];
      srcSel_q <= sfrWrData[`CSD_SRC_MSB:`CSD_SRC_LSB];
    end
  end

  // External oscillator control; bit 7 is status and bit 3 is dropped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      xMode_q <= csd_pkg::csd_xmode_t'(`CSD_RST_XMODE);
      xBias_q <= `CSD_RST_XBIAS;
    end else if (sfrWrEn && sfrAddr == `CSD_ADDR_EXT_OSC_CONTROL) begin
      xMode_q <= csd_pkg::csd_xmode_t'(sfrWrData[`CSD_XMODE_MSB:`CSD_XMODE_LSB]);
      xBias_q <= sfrWrData[`CSD_XBIAS_MSB:`CSD_XBIAS_LSB];
    end
  end

  // ----------------------------------------------------------------------------
  // External oscillator conditioning
  // ----------------------------------------------------------------------------
  assign xCmosMode = (xMode_q == csd_pkg::XM_CMOS) || (xMode_q == csd_pkg::XM_CMOS_DIV2);
  assign xRunMode  = (xMode_q == csd_pkg::XM_RC) || (xMode_q == csd_pkg::XM_CAP) ||
                     (xMode_q == csd_pkg::XM_XTAL_DIV2);
  assign extOscEnable = xCmosMode | xRunMode;
  assign extRaw       = tick[1] & extOscEnable;

  // Divide-by-2 stage in the halving modes keeps every other edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      xHalf_q <= 1'b0;
    end else if (!extOscEnable) begin
      xHalf_q <= 1'b0;
    end else if (extRaw) begin
      xHalf_q <= ~xHalf_q;
    end
  end

  assign extTick = ((xMode_q == csd_pkg::XM_CMOS_DIV2) || (xMode_q == csd_pkg::XM_XTAL_DIV2))
                   ? (extRaw & xHalf_q) : extRaw;

  // ----------------------------------------------------------------------------
  // External oscillator valid detector
  // ----------------------------------------------------------------------------
  // Valid after a run of edges with no long gap; a gap or mode change restarts it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      xStartCnt_q <= 11'h000;
      xGapCnt_q   <= 11'h000;
      xValid_q    <= 1'b0;
    end else if (!xRunMode || (sfrWrEn && sfrAddr == `CSD_ADDR_EXT_OSC_CONTROL)) begin
      xStartCnt_q <= 11'h000;
      xGapCnt_q   <= 11'h000;
      xValid_q    <= 1'b0;
    end else if (extRaw) begin
      xGapCnt_q <= 11'h000;
      if (xStartCnt_q == `CSD_XSTART_TICKS - 11'h001) begin
        xValid_q <= 1'b1;
      end else if (!xValid_q) begin
        xStartCnt_q <= xStartCnt_q + 11'h001;
      end
    end else if (xGapCnt_q == 11'(`CSD_XGAP_CYCLES - 1)) begin
      xStartCnt_q <= 11'h000;
      xValid_q    <= 1'b0;
    end else begin
      xGapCnt_q <= xGapCnt_q + 11'h001;
    end
  end

  // CMOS input has no detector; the flag is forced low there
  assign xValidRead = xValid_q & ~xCmosMode;

  // ----------------------------------------------------------------------------
  // Source multiplexer
  // ----------------------------------------------------------------------------
  // Reserved codes keep the last legal source so the clock never stops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      activeSrc_q <= csd_pkg::SRC_LOW_POWER;
    end else begin
      case (srcSel_q)
        3'b000:  activeSrc_q <= csd_pkg::SRC_PRECISION;
        3'b001:  activeSrc_q <= csd_pkg::SRC_EXTERNAL;
        3'b011:  activeSrc_q <= csd_pkg::SRC_RTC;
        3'b100:  activeSrc_q <= csd_pkg::SRC_LOW_POWER;
        default: activeSrc_q <= activeSrc_q;
      endcase
    end
  end

  // Ticks are whole pulses, so switching between them cannot cut one short
  always_comb begin
    case (activeSrc_q)
      csd_pkg::SRC_PRECISION: srcTick = tick[0];
      csd_pkg::SRC_EXTERNAL:  srcTick = extTick;
      csd_pkg::SRC_RTC:       srcTick = tick[2];
      csd_pkg::SRC_LOW_POWER: srcTick = tick[3];
      default:                srcTick = 1'b0;
    endcase
  end

  assign lowPowerOscEnable = (activeSrc_q == csd_pkg::SRC_LOW_POWER);

  // ----------------------------------------------------------------------------
  // Power-of-two divider
  // ----------------------------------------------------------------------------
  // Terminal count is 2^div - 1 source ticks
  assign divLast = 7'h7f >> (3'd7 - activeDiv_q);

  // A new divide is taken only at a period boundary, so no short period
  // appears; the cost is a wait of up to 128 source ticks
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      divCnt_q    <= 7'h00;
      activeDiv_q <= `CSD_RST_DIV;
      applied_q   <= 1'b0;
      coreTick_q  <= 1'b0;
    end else begin
      coreTick_q <= 1'b0;
      if (srcTick) begin
        if (divCnt_q >= divLast) begin
          divCnt_q    <= 7'h00;
          coreTick_q  <= 1'b1;
          activeDiv_q <= divSel_q;
          applied_q   <= 1'b1;
        end else begin
          divCnt_q <= divCnt_q + 7'h01;
        end
      end
    end
  end

  assign coreClockOut = coreTick_q;

  // Ready once the divider runs with the value software last wrote
  assign dividerReady = applied_q && (activeDiv_q == divSel_q);

  // ----------------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------------
  // Read data appears one cycle after the read strobe; unmapped reads give 0
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdData_q <= 8'h00;
    end else if (sfrRdEn) begin
      case (sfrAddr)
        `CSD_ADDR_CLOCK_SELECT:    rdData_q <= {dividerReady, divSel_q, 1'b0, srcSel_q};
        `CSD_ADDR_EXT_OSC_CONTROL: rdData_q <= {xValidRead, xMode_q, 1'b0, xBias_q};
        default:                   rdData_q <= 8'h00;
      endcase
    end
  end

  assign sfrRdData = rdData_q;

endmodule : csd_clock_select

// ===== verilog/csd_pin_sync.sv
// Three-stage synchroniser with rising edge pulse for an oscillator pin
`timescale 1ns/100ps
module csd_pin_sync (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic pinIn,
  output logic      risePulse
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic stable_q;
  logic rise_q;

  // ----------------------------------------------------------------------------
  // Sync chain; only the second stage reads the first
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stable_q <= 1'b0;
      rise_q   <= 1'b0;
    end else begin
      rise_q <= 1'b0;
      if (s2_q == s3_q) begin
        stable_q <= s2_q;
        rise_q   <= s2_q & ~stable_q;
      end
    end
  end

  assign risePulse = rise_q;

endmodule : csd_pin_sync
